// [bench/pbm_host.sv]
// management host model: one register access at a time, request fields held until ack
// assumes the block takes a one-cycle request and acks it one cycle later on clk_sys
`timescale 1ns/1ps
`default_nettype none
module pbm_host (
    input wire logic clk_sys,
    output logic mgmt_req,
    output logic mgmt_write,
    output logic [4:0] mgmt_index,
    output logic [15:0] mgmt_wdata,
    input wire logic mgmt_ack,
    input wire logic [15:0] mgmt_rdata
);
    initial begin
        mgmt_req = 1'b0;
        mgmt_write = 1'b0;
        mgmt_index = 5'h1f;
        mgmt_wdata = 16'ha5a5;
    end
    // a lost ack returns unknown data so the caller's compare fails
    task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
        output logic [15:0] rd);
        int n;
        @(posedge clk_sys);
        mgmt_req <= 1'b1;
        mgmt_write <= wr;
        mgmt_index <= idx;
        mgmt_wdata <= wd & 16'hfb80;
        @(posedge clk_sys);
        mgmt_req <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (mgmt_ack !== 1'b1 && n < 4);
        rd = (mgmt_ack === 1'b1) ? mgmt_rdata : 16'hxxxx;
        // released fields show a changed value, not the last one
        mgmt_write <= ~wr;
        mgmt_index <= ~idx;
        mgmt_wdata <= ~mgmt_wdata;
    endtask
endmodule // pbm_host
`default_nettype wire

// [bench/pbm_regs_tb.sv]
// self-checking bench for the phy management register block
// assumes a host model on the management port; all other inputs driven by the scenarios
`timescale 1ns/1ps
`default_nettype none
module pbm_regs_tb;
    import pbm_pkg::*;
    logic clk_sys, rst, mgmt_req, mgmt_write, mgmt_ack, mgmt_busy, tx_enable;
    logic [4:0] mgmt_index;
    logic [15:0] mgmt_wdata, mgmt_rdata, d;
    logic [3:0] tx_nibble_data, rx_nibble_data, rx_medium_data;
    logic rx_medium_valid, an_speed_100_in, an_full_duplex_in;
    logic link_ok_in, jabber_in, an_done_in, loopback_cfg_valid_in, loopback_cfg_in;
    logic full_duplex_only_in, rx_data_valid, collision, speed_100, full_duplex;
    logic power_down, an_enable, an_restart, medium_isolate;
    int num_errors = 0, samples_checked = 0, restart_cnt, busy_cnt, dead_cnt;
    pbm_host host_u (.clk_sys(clk_sys), .mgmt_req(mgmt_req), .mgmt_write(mgmt_write),
        .mgmt_index(mgmt_index), .mgmt_wdata(mgmt_wdata), .mgmt_ack(mgmt_ack),
        .mgmt_rdata(mgmt_rdata));
    // identifier words are arbitrary values
    pbm_regs #(.ID_HIGH(16'h2468), .ID_LOW(16'h1357)) dut_u (.clk_sys(clk_sys), .rst(rst),
        .mgmt_req(mgmt_req), .mgmt_write(mgmt_write), .mgmt_index(mgmt_index),
        .mgmt_wdata(mgmt_wdata), .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata),
        .mgmt_busy(mgmt_busy), .tx_nibble_data(tx_nibble_data), .tx_enable(tx_enable),
        .rx_medium_data(rx_medium_data), .rx_medium_valid(rx_medium_valid),
        .link_ok_in(link_ok_in), .jabber_in(jabber_in), .an_done_in(an_done_in),
        .an_speed_100_in(an_speed_100_in), .an_full_duplex_in(an_full_duplex_in),
        .loopback_cfg_valid_in(loopback_cfg_valid_in),
        .loopback_cfg_in(loopback_cfg_in), .full_duplex_only_in(full_duplex_only_in),
        .rx_nibble_data(rx_nibble_data), .rx_data_valid(rx_data_valid),
        .collision(collision), .speed_100(speed_100), .full_duplex(full_duplex),
        .power_down(power_down), .an_enable(an_enable), .an_restart(an_restart),
        .medium_isolate(medium_isolate));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (an_restart === 1'b1) restart_cnt++;
        if (mgmt_busy === 1'b1) busy_cnt++;
        if (medium_isolate === 1'b1 && rx_data_valid === 1'b0) dead_cnt++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [4:0] idx, input logic [15:0] exp);
        host_u.access(1'b0, idx, 16'h0000, d);
        chk(d, exp);
    endtask
    task automatic wrc(input logic [15:0] w);
        host_u.access(1'b1, IDX_CONTROL, w, d);
    endtask
    // speed, duplex, power-down and negotiation-enable outputs once settled
    task automatic chko(input logic [3:0] e);
        repeat (4) @(posedge clk_sys);
        chk({12'h000, speed_100, full_duplex, power_down, an_enable}, {12'h000, e});
    endtask
    task automatic t_reset();
        rdc(IDX_CONTROL, CTL_RESET_VAL);
        rdc(IDX_STATUS, 16'h7809);
        host_u.access(1'b1, IDX_ID_HIGH, 16'h0000, d);
        rdc(IDX_ID_HIGH, 16'h2468);
        rdc(IDX_ID_LOW, 16'h1357);
        rdc(5'h04, DATA_ZERO);
    endtask
    task automatic t_status();
        rdc(IDX_STATUS, 16'h780d);
        @(posedge clk_sys);
        link_ok_in <= 1'b0;
        jabber_in <= 1'b1;
        repeat (4) @(posedge clk_sys);
        link_ok_in <= 1'b1;
        jabber_in <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rdc(IDX_STATUS, 16'h780b);
        rdc(IDX_STATUS, 16'h780d);
        an_done_in <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rdc(IDX_STATUS, 16'h782d);
    endtask
    task automatic t_ctrl();
        wrc(16'h0900);
        chko(4'b0110);
        rdc(IDX_CONTROL, 16'h0900);
        an_speed_100_in <= 1'b1;
        an_full_duplex_in <= 1'b1;
        wrc(16'h1000);
        chko(4'b1101);
        an_speed_100_in <= 1'b0;
        an_full_duplex_in <= 1'b0;
        wrc(16'h2000);
        full_duplex_only_in <= 1'b1;
        chko(4'b1100);
        rdc(IDX_CONTROL, 16'h2100);
        full_duplex_only_in <= 1'b0;
    endtask
    task automatic t_col();
        wrc(16'h3080);
        tx_enable <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk({15'h0000, collision}, 16'h0001);
        wrc(16'h3000);
        repeat (3) @(posedge clk_sys);
        chk({15'h0000, collision}, 16'h0000);
        tx_enable <= 1'b0;
    endtask
    task automatic t_restart();
        restart_cnt = 0;
        wrc(16'h3200);
        repeat (4) @(posedge clk_sys);
        chk(16'(restart_cnt), 16'h0001);
        rdc(IDX_CONTROL, 16'h3000);
    endtask
    task automatic t_loop();
        loopback_cfg_valid_in <= 1'b1;
        tx_enable <= 1'b1;
        tx_nibble_data <= 4'h5;
        rx_medium_data <= 4'ha;
        rx_medium_valid <= 1'b1;
        wrc(16'h4000);
        repeat (4) @(posedge clk_sys);
        chk({11'h000, medium_isolate, rx_data_valid, rx_nibble_data}, 16'h001a);
        dead_cnt = 0;
        loopback_cfg_valid_in <= 1'b0;
        repeat (40) @(posedge clk_sys);
        chk(16'(dead_cnt), 16'(DEAD_TIME_NS / CLK_PERIOD_NS));
        chk({11'h000, medium_isolate, rx_data_valid, rx_nibble_data}, 16'h0035);
        chk({15'h0000, full_duplex}, 16'h0001);
        wrc(16'h3000);
        tx_enable <= 1'b0;
    endtask
    task automatic t_soft();
        int n;
        wrc(16'h0800);
        busy_cnt = 0;
        wrc(16'h8000);
        rdc(IDX_CONTROL, 16'hb000);
        wrc(16'h0000);
        for (n = 0; n < 40 && mgmt_busy !== 1'b0; n++) @(posedge clk_sys);
        rdc(IDX_CONTROL, CTL_RESET_VAL);
        rdc(IDX_STATUS, 16'h7829);
        chk(16'(busy_cnt), 16'h0010);
    endtask
    task automatic complete_run();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #50us;
        num_errors++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        tx_enable = 1'b0;
        tx_nibble_data = 4'h0;
        link_ok_in = 1'b1;
        jabber_in = 1'b0;
        an_done_in = 1'b0;
        loopback_cfg_valid_in = 1'b0;
        loopback_cfg_in = 1'b0;
        full_duplex_only_in = 1'b0;
        rx_medium_data = 4'h0;
        rx_medium_valid = 1'b0;
        an_speed_100_in = 1'b0;
        an_full_duplex_in = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_status();
        t_ctrl();
        t_col();
        t_restart();
        t_loop();
        t_soft();
        complete_run();
    end
endmodule // pbm_regs_tb
`default_nettype wire

// [verilog/pbm_pkg.sv]
// constants for the basic management register set of a 10/100 phy unit
// assumes a single 50 MHz clock and a management host using register indices
package pbm_pkg;
    localparam int IDX_W = 5;
    localparam int DATA_W = 16;
    localparam int NIB_W = 4;
    localparam logic [4:0] IDX_CONTROL = 5'h00;
    localparam logic [4:0] IDX_STATUS = 5'h01;
    localparam logic [4:0] IDX_ID_HIGH = 5'h02;
    localparam logic [4:0] IDX_ID_LOW = 5'h03;
    // control field positions
    localparam int CTL_RESET = 15;
    localparam int CTL_LOOPBACK = 14;
    localparam int CTL_SPEED = 13;
    localparam int CTL_AN_EN = 12;
    localparam int CTL_POWER_DOWN = 11;
    localparam int CTL_AN_RESTART = 9;
    localparam int CTL_DUPLEX = 8;
    localparam int CTL_COL_TEST = 7;
    localparam logic [15:0] CTL_RESET_VAL = 16'h3000;
    // bits 15 and 9 are never stored: they clear themselves
    localparam logic [15:0] CTL_STORE_MASK = 16'h7dff;
    // status field positions
    localparam int STS_AN_DONE = 5;
    localparam int STS_LINK = 2;
    localparam int STS_JABBER = 1;
    // abilities 14:11, an ability 3, extended 0; bits 6 and 4 read zero
    localparam logic [15:0] STS_FIXED = 16'h7809;
    localparam logic [15:0] DATA_ZERO = 16'h0000;
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int DEAD_TIME_NS = 560;
    localparam int DEAD_CYCLES = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SOFT_RESET_CYCLES = 16;
    localparam int CNT_W = 6;
    localparam logic [5:0] DEAD_LOAD = 6'(DEAD_CYCLES - 1);
    localparam logic [5:0] SOFT_LOAD = 6'(SOFT_RESET_CYCLES - 1);
    localparam logic [5:0] CNT_ZERO = 6'h00;
    localparam logic [5:0] CNT_ONE = 6'h01;
    // synchroniser bundle layout
    localparam int SYN_W = 13;
    localparam int SY_LINK = 12;
    localparam int SY_JAB = 11;
    localparam int SY_AN_DONE = 10;
    localparam int SY_AN_SPD = 9;
    localparam int SY_AN_FDX = 8;
    localparam int SY_CFG_VALID = 7;
    localparam int SY_CFG_LB = 6;
    localparam int SY_MED_VALID = 5;
    localparam int SY_FDX_ONLY = 4;
    localparam int SY_MED_DATA = 0;
    typedef enum logic [0:0] {
        PBM_RUN = 1'b0,
        PBM_SOFT_RESET = 1'b1
    } pbm_phase_t;
endpackage

// [verilog/pbm_regs.sv]
// basic control, status and identifier registers of a 10/100 phy unit
// medium-side inputs are asynchronous; management and transmit inputs share clk_sys
`timescale 1ns/1ps
`default_nettype none
module pbm_regs #(
    parameter logic [15:0] ID_HIGH = 16'h1234, // arbitrary value
    parameter logic [15:0] ID_LOW = 16'h5678 // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic mgmt_req,
    input wire logic mgmt_write,
    input wire logic [pbm_pkg::IDX_W-1:0] mgmt_index,
    input wire logic [pbm_pkg::DATA_W-1:0] mgmt_wdata,
    output logic mgmt_ack,
    output logic [pbm_pkg::DATA_W-1:0] mgmt_rdata,
    output logic mgmt_busy,
    input wire logic [pbm_pkg::NIB_W-1:0] tx_nibble_data,
    input wire logic tx_enable,
    input wire logic [pbm_pkg::NIB_W-1:0] rx_medium_data,
    input wire logic rx_medium_valid,
    input wire logic link_ok_in,
    input wire logic jabber_in,
    input wire logic an_done_in,
    input wire logic an_speed_100_in,
    input wire logic an_full_duplex_in,
    input wire logic loopback_cfg_valid_in,
    input wire logic loopback_cfg_in,
    input wire logic full_duplex_only_in,
    output logic [pbm_pkg::NIB_W-1:0] rx_nibble_data,
    output logic rx_data_valid,
    output logic collision,
    output logic speed_100,
    output logic full_duplex,
    output logic power_down,
    output logic an_enable,
    output logic an_restart,
    output logic medium_isolate
);
    import pbm_pkg::*;

    logic [SYN_W-1:0] sync1_reg, sync1_next;
    logic [SYN_W-1:0] sync2_reg, sync2_next;
    pbm_phase_t phase_reg, phase_next;
    logic [CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
    logic [CNT_W-1:0] dead_cnt_reg, dead_cnt_next;
    logic [DATA_W-1:0] ctrl_reg, ctrl_next;
    logic link_latching_low_reg, link_latching_low_next;
    logic jab_latching_high_reg, jab_latching_high_next;
    logic lb_active_reg, lb_active_next;
    logic ack_reg, ack_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [NIB_W-1:0] rx_data_reg, rx_data_next;
    logic rx_valid_reg, rx_valid_next;
    logic col_reg, col_next;
    logic spd_reg, spd_next;
    logic fdx_reg, fdx_next;
    logic pd_reg, pd_next;
    logic an_en_reg, an_en_next;
    logic restart_reg, restart_next;
    logic do_read, do_write;
    logic lb_now;
    logic duplex_bit;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] ctrl_view;

    // register selection by index, used for reads and writes
    function automatic logic [1:0] sel_reg(input logic [IDX_W-1:0] idx);
        logic [1:0] s;
        s = 2'h0;
        if (idx == IDX_CONTROL) begin
            s = 2'h1;
        end else if (idx == IDX_STATUS) begin
            s = 2'h2;
        end else if (idx == IDX_ID_HIGH || idx == IDX_ID_LOW) begin
            s = 2'h3;
        end
        return s;
    endfunction

    always_comb begin
        sync1_next = {link_ok_in, jabber_in, an_done_in, an_speed_100_in, an_full_duplex_in,
                      loopback_cfg_valid_in, loopback_cfg_in, rx_medium_valid,
                      full_duplex_only_in, rx_medium_data};
        sync2_next = sync1_reg;
        do_read = mgmt_req && !mgmt_write;
        // writes are refused while the soft reset runs
        do_write = mgmt_req && mgmt_write && phase_reg == PBM_RUN;
        // configuration setting, when present, decides loopback
        lb_now = sync2_reg[SY_CFG_VALID] ? sync2_reg[SY_CFG_LB] : ctrl_reg[CTL_LOOPBACK];
        // a single-duplex phy shows its only mode in bit 8
        duplex_bit = sync2_reg[SY_FDX_ONLY] ? 1'b1 : ctrl_reg[CTL_DUPLEX];
        ctrl_view = ctrl_reg;
        ctrl_view[CTL_DUPLEX] = duplex_bit;
        ctrl_view[CTL_RESET] = (phase_reg == PBM_SOFT_RESET);
        status_word = STS_FIXED;
        status_word[STS_AN_DONE] = sync2_reg[SY_AN_DONE] && ctrl_reg[CTL_AN_EN];
        status_word[STS_LINK] = link_latching_low_reg;
        status_word[STS_JABBER] = jab_latching_high_reg;

        phase_next = phase_reg;
        rst_cnt_next = rst_cnt_reg;
        ctrl_next = ctrl_reg;
        restart_next = 1'b0;
        case (phase_reg)
            PBM_RUN: begin
                if (do_write && sel_reg(mgmt_index) == 2'h1) begin
                    if (mgmt_wdata[CTL_RESET]) begin
                        phase_next = PBM_SOFT_RESET;
                        rst_cnt_next = SOFT_LOAD;
                        ctrl_next = CTL_RESET_VAL;
                    end else begin
                        ctrl_next = mgmt_wdata & CTL_STORE_MASK;
                        restart_next = mgmt_wdata[CTL_AN_RESTART];
                    end
                end
            end
            PBM_SOFT_RESET: begin
                ctrl_next = CTL_RESET_VAL;
                if (rst_cnt_reg == CNT_ZERO) begin
                    phase_next = PBM_RUN;
                end else begin
                    rst_cnt_next = rst_cnt_reg - CNT_ONE;
                end
            end
            default: begin
                phase_next = PBM_RUN;
            end
        endcase

        // a read reloads the latch from the live level; a new event still wins
        if (phase_reg == PBM_SOFT_RESET) begin
            link_latching_low_next = 1'b0;
            jab_latching_high_next = 1'b0;
        end else if (do_read && sel_reg(mgmt_index) == 2'h2) begin
            link_latching_low_next = sync2_reg[SY_LINK];
            jab_latching_high_next = sync2_reg[SY_JAB];
        end else begin
            link_latching_low_next = link_latching_low_reg && sync2_reg[SY_LINK];
            jab_latching_high_next = jab_latching_high_reg || sync2_reg[SY_JAB];
        end

        ack_next = mgmt_req;
        rdata_next = DATA_ZERO;
        if (do_read) begin
            if (sel_reg(mgmt_index) == 2'h1) begin
                rdata_next = ctrl_view;
            end else if (sel_reg(mgmt_index) == 2'h2) begin
                rdata_next = status_word;
            end else if (mgmt_index == IDX_ID_HIGH) begin
                rdata_next = ID_HIGH;
            end else if (mgmt_index == IDX_ID_LOW) begin
                rdata_next = ID_LOW;
            end
        end

        // loopback entry blanks received data for the descrambler dead time
        lb_active_next = lb_now;
        if (lb_now && !lb_active_reg) begin
            dead_cnt_next = DEAD_LOAD;
        end else if (dead_cnt_reg != CNT_ZERO) begin
            dead_cnt_next = dead_cnt_reg - CNT_ONE;
        end else begin
            dead_cnt_next = CNT_ZERO;
        end
        if (lb_now) begin
            rx_data_next = tx_nibble_data;
            rx_valid_next = tx_enable && lb_active_reg && dead_cnt_reg == CNT_ZERO;
        end else begin
            rx_data_next = sync2_reg[SY_MED_DATA +: NIB_W];
            rx_valid_next = sync2_reg[SY_MED_VALID];
        end

        col_next = ctrl_reg[CTL_COL_TEST] && tx_enable;
        an_en_next = ctrl_reg[CTL_AN_EN];
        spd_next = ctrl_reg[CTL_AN_EN] ? sync2_reg[SY_AN_SPD] : ctrl_reg[CTL_SPEED];
        if (lb_now) begin
            fdx_next = 1'b1;
        end else if (ctrl_reg[CTL_AN_EN]) begin
            fdx_next = sync2_reg[SY_AN_FDX];
        end else begin
            fdx_next = duplex_bit;
        end
        pd_next = ctrl_reg[CTL_POWER_DOWN];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            phase_reg <= PBM_RUN;
            rst_cnt_reg <= CNT_ZERO;
            dead_cnt_reg <= CNT_ZERO;
            ctrl_reg <= CTL_RESET_VAL;
            link_latching_low_reg <= 1'b0;
            jab_latching_high_reg <= 1'b0;
            lb_active_reg <= 1'b0;
            ack_reg <= 1'b0;
            rdata_reg <= DATA_ZERO;
            rx_data_reg <= '0;
            rx_valid_reg <= 1'b0;
            col_reg <= 1'b0;
            spd_reg <= 1'b0;
            fdx_reg <= 1'b0;
            pd_reg <= 1'b0;
            an_en_reg <= 1'b0;
            restart_reg <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            phase_reg <= phase_next;
            rst_cnt_reg <= rst_cnt_next;
            dead_cnt_reg <= dead_cnt_next;
            ctrl_reg <= ctrl_next;
            link_latching_low_reg <= link_latching_low_next;
            jab_latching_high_reg <= jab_latching_high_next;
            lb_active_reg <= lb_active_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            rx_data_reg <= rx_data_next;
            rx_valid_reg <= rx_valid_next;
            col_reg <= col_next;
            spd_reg <= spd_next;
            fdx_reg <= fdx_next;
            pd_reg <= pd_next;
            an_en_reg <= an_en_next;
            restart_reg <= restart_next;
        end
    end

    assign mgmt_ack = ack_reg;
    assign mgmt_rdata = rdata_reg;
    assign mgmt_busy = phase_reg;
    assign rx_nibble_data = rx_data_reg;
    assign rx_data_valid = rx_valid_reg;
    assign collision = col_reg;
    assign speed_100 = spd_reg;
    assign full_duplex = fdx_reg;
    assign power_down = pd_reg;
    assign an_enable = an_en_reg;
    assign an_restart = restart_reg;
    assign medium_isolate = lb_active_reg;

    chk_soft_reset_busy: assert property (@(posedge clk_sys) disable iff (rst)
        (mgmt_req && mgmt_write && !mgmt_busy && mgmt_index == IDX_CONTROL
         && mgmt_wdata[CTL_RESET])
        |=> mgmt_busy [*8] ##[1:12] !mgmt_busy)
        else $error("soft reset did not hold busy for its duration");

    chk_loop_route_data: assert property (@(posedge clk_sys) disable iff (rst)
        (lb_now && lb_active_reg && dead_cnt_reg == CNT_ZERO && tx_enable)
        |=> (rx_data_valid && rx_nibble_data == $past(tx_nibble_data)))
        else $error("loopback did not route transmit nibble to receive path");

    chk_dead_time_gap: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(medium_isolate) |-> !rx_data_valid [*8])
        else $error("receive data valid inside loopback dead time");

    chk_loop_cfg_wins: assert property (@(posedge clk_sys) disable iff (rst)
        (sync2_reg[SY_CFG_VALID] && !sync2_reg[SY_CFG_LB] && ctrl_reg[CTL_LOOPBACK])
        |=> !medium_isolate)
        else $error("loopback bit overrode the configuration setting");

    chk_speed_ignored: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_reg[CTL_AN_EN] |=> (speed_100 == $past(sync2_reg[SY_AN_SPD]) && an_enable))
        else $error("speed bit used while autonegotiation enabled");

    chk_duplex_in_loop: assert property (@(posedge clk_sys) disable iff (rst)
        lb_now |=> full_duplex)
        else $error("duplex output depends on duplex bit in loopback");

    chk_collision_test: assert property (@(posedge clk_sys) disable iff (rst)
        (ctrl_reg[CTL_COL_TEST] && tx_enable) |=> collision)
        else $error("collision test did not force collision");

    chk_restart_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        (mgmt_req && mgmt_write && !mgmt_busy && mgmt_index == IDX_CONTROL
         && !mgmt_wdata[CTL_RESET] && mgmt_wdata[CTL_AN_RESTART])
        |=> an_restart ##1 !an_restart)
        else $error("autonegotiation restart not a single pulse");

    chk_status_fixed: assert property (@(posedge clk_sys) disable iff (rst)
        (mgmt_req && !mgmt_write && mgmt_index == IDX_STATUS)
        |=> (mgmt_ack && mgmt_rdata[14:11] == 4'hf && !mgmt_rdata[6] && !mgmt_rdata[4]
             && mgmt_rdata[3] && mgmt_rdata[0]))
        else $error("status fixed bits wrong");

    chk_link_latch_low: assert property (@(posedge clk_sys) disable iff (rst)
        (!sync2_reg[SY_LINK]) |=> !link_latching_low_reg)
        else $error("link drop not latched low");

    chk_jabber_latch: assert property (@(posedge clk_sys) disable iff (rst)
        (jab_latching_high_reg && !(mgmt_req && !mgmt_write && mgmt_index == IDX_STATUS))
        |=> jab_latching_high_reg || mgmt_busy)
        else $error("jabber flag dropped without a read");

    chk_id_words: assert property (@(posedge clk_sys) disable iff (rst)
        (mgmt_req && !mgmt_write && mgmt_index == IDX_ID_HIGH)
        |=> (mgmt_ack && mgmt_rdata == ID_HIGH))
        else $error("identifier high word wrong");

    chk_id_low_word: assert property (@(posedge clk_sys) disable iff (rst)
        (mgmt_req && !mgmt_write && mgmt_index == IDX_ID_LOW)
        |=> (mgmt_ack && mgmt_rdata == ID_LOW))
        else $error("identifier low word wrong");

    chk_unmapped_reads_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (mgmt_req && !mgmt_write && mgmt_index > IDX_ID_LOW)
        |=> (mgmt_ack && mgmt_rdata == DATA_ZERO))
        else $error("unmapped index did not read zero");

    chk_reset_bit_reads: assert property (@(posedge clk_sys) disable iff (rst)
        (mgmt_req && !mgmt_write && mgmt_index == IDX_CONTROL && mgmt_busy)
        |=> mgmt_rdata[CTL_RESET])
        else $error("reset bit not read as one during soft reset");

    chk_self_clear_bits: assert property (@(posedge clk_sys) disable iff (rst)
        (mgmt_req && !mgmt_write && mgmt_index == IDX_CONTROL && !mgmt_busy)
        |=> (!mgmt_rdata[CTL_RESET] && !mgmt_rdata[CTL_AN_RESTART]))
        else $error("self clearing control bit read as one");

    chk_speed_manual: assert property (@(posedge clk_sys) disable iff (rst)
        !ctrl_reg[CTL_AN_EN] |=> speed_100 == $past(ctrl_reg[CTL_SPEED]))
        else $error("speed output does not follow speed bit");

    chk_duplex_manual: assert property (@(posedge clk_sys) disable iff (rst)
        (!ctrl_reg[CTL_AN_EN] && !lb_now && !sync2_reg[SY_FDX_ONLY])
        |=> full_duplex == $past(ctrl_reg[CTL_DUPLEX]))
        else $error("duplex output does not follow duplex bit");

    chk_single_duplex: assert property (@(posedge clk_sys) disable iff (rst)
        (mgmt_req && !mgmt_write && mgmt_index == IDX_CONTROL && sync2_reg[SY_FDX_ONLY])
        |=> mgmt_rdata[CTL_DUPLEX])
        else $error("duplex bit does not show the only supported mode");

    chk_power_down_follows: assert property (@(posedge clk_sys) disable iff (rst)
        (mgmt_req && mgmt_write && !mgmt_busy && mgmt_index == IDX_CONTROL
         && !mgmt_wdata[CTL_RESET] && mgmt_wdata[CTL_POWER_DOWN])
        |=> ##1 power_down)
        else $error("power down bit did not reach the output");

    chk_an_done_bit: assert property (@(posedge clk_sys) disable iff (rst)
        (mgmt_req && !mgmt_write && mgmt_index == IDX_STATUS && sync2_reg[SY_AN_DONE]
         && ctrl_reg[CTL_AN_EN])
        |=> mgmt_rdata[STS_AN_DONE])
        else $error("negotiation complete not reported");

    chk_link_holds_low: assert property (@(posedge clk_sys) disable iff (rst)
        (!link_latching_low_reg && !mgmt_busy
         && !(mgmt_req && !mgmt_write && mgmt_index == IDX_STATUS))
        |=> !link_latching_low_reg)
        else $error("link flag rose without a status read");
endmodule // pbm_regs
`default_nettype wire
